// ===== hw/tuwd_pkg.sv
// Shared constants and types for the three-wide uop dispatch core
package tuwd_pkg;
  localparam int DEC_WIDTH     = 3;
  localparam int ALLOC_UOPS    = 3;
  localparam int RET_WIDTH     = 3;
  localparam int DEC_BYTES     = 20;
  localparam int VEC_BITS      = 128;
  localparam int DTLB2_ENTRIES = 512;
  localparam int DTLB2_PAGE_KB = 4;
  localparam int ITLB_ENTRIES  = 48;
  localparam int IQ_DEPTH      = 8;
  localparam int RS_DEPTH      = 4;
  localparam int ROB_DEPTH     = 16;
  localparam int ROB_W         = 4;
  localparam int LEN_W         = 5;
  localparam int ID_W          = 8;
  // Stations: three integer, one vector, one memory
  localparam int N_STN         = 5;
  localparam int STN_VEC       = 3;
  localparam int STN_MEM       = 4;
  // Lanes: int ports 0..2, vector ports 0..1, load, store
  localparam int N_LANE        = 7;
  localparam int LN_VEC0       = 3;
  localparam int LN_VEC1       = 4;
  localparam int LN_LOAD       = 5;
  localparam int LN_STORE      = 6;

  typedef enum logic [3:0] {
    OP_ALU, OP_SHIFT, OP_LEA, OP_F2I, OP_STD, OP_BIT, OP_BRANCH, OP_MUL,
    OP_DIV, OP_POPCNT, OP_CRC, OP_FLAGM, OP_VALU, OP_VSHUF, OP_FMUL, OP_FADD
  } tuwd_op_t;

  typedef enum logic [1:0] {MEM_NONE, MEM_LOAD, MEM_STORE} tuwd_mem_t;

  typedef struct packed {
    tuwd_mem_t          mem;
    logic               has_op;
    tuwd_op_t           op;
    logic [LEN_W-1:0]   len;
    logic [ID_W-1:0]    id;
  } tuwd_insn_t;

  typedef struct packed {
    tuwd_op_t           op;
    tuwd_mem_t          mem;
    logic               is_mem;
    logic               wait_mem;
    logic [ROB_W-1:0]   rob;
    logic [ID_W-1:0]    id;
  } tuwd_uop_t;

  typedef struct packed {
    logic [ROB_W-1:0]   rob;
    logic               is_mem;
  } tuwd_cmp_t;
endpackage

// ===== hw/tuwd_core.sv
// Three-wide decode, split, steer, dispatch and retire core
`timescale 1ns/1ns
module tuwd_core
  import tuwd_pkg::*;
#(
  parameter int IQ_N    = IQ_DEPTH,
  parameter int RS_N    = RS_DEPTH,
  parameter int ROB_N   = ROB_DEPTH,
  parameter int DTLB2_N = DTLB2_ENTRIES,
  parameter int ITLB_N  = ITLB_ENTRIES,
  parameter int VEC_W   = VEC_BITS
) (
  input  wire logic                       mclk,
  input  wire logic                       resetn,
  input  wire logic [1:0]                 fetch_count,
  input  wire tuwd_insn_t [DEC_WIDTH-1:0] fetch_insn,
  output      logic                       fetch_ready,
  output      logic [N_LANE-1:0]          issue_valid,
  output      tuwd_uop_t [N_LANE-1:0]     issue_uop,
  input  wire logic [N_LANE-1:0]          cmp_valid,
  input  wire tuwd_cmp_t [N_LANE-1:0]     cmp_info,
  output      logic [RET_WIDTH-1:0]       ret_valid,
  output      logic [RET_WIDTH-1:0][ID_W-1:0] ret_id
);
  localparam int IQ_W = $clog2(IQ_N);
  localparam int RS_W = $clog2(RS_N);

  if (DTLB2_N != DTLB2_ENTRIES || DTLB2_PAGE_KB != 4)
    $error("second-level data TLB size unsupported");
  if (ITLB_N != ITLB_ENTRIES)
    $error("instruction TLB size unsupported");
  if (VEC_W != VEC_BITS)
    $error("vector datapath width unsupported");
  if (IQ_N != 2**IQ_W || IQ_N < DEC_WIDTH)
    $error("IQ_N must be a power of two of at least DEC_WIDTH");
  if (ROB_N != 2**ROB_W || RS_N < 2)
    $error("ROB_N must match ROB_W and RS_N must be at least two");

  tuwd_insn_t                    iq_reg [IQ_N];
  logic [IQ_W-1:0]               iq_head_reg;
  logic [IQ_W:0]                 iq_cnt_reg;
  logic [1:0]                    push_n;
  logic [1:0]                    take_n;
  logic [N_STN-1:0][RS_N-1:0]    st_v_reg;
  logic [N_STN-1:0][RS_N-1:0]    st_v_next;
  tuwd_uop_t                     st_u_reg [N_STN][RS_N];
  tuwd_uop_t                     st_u_next [N_STN][RS_N];
  logic [N_LANE-1:0]             pick_ok;
  logic [RS_W-1:0]               pick_idx [N_LANE];
  logic [ROB_N-1:0]              rob_v_reg;
  logic [ROB_N-1:0]              rob_dm_reg;
  logic [ROB_N-1:0]              rob_dc_reg;
  logic [ID_W-1:0]               rob_id_reg [ROB_N];
  logic [ROB_W-1:0]              rob_head_reg;
  logic [ROB_W:0]                rob_cnt_reg;
  logic [DEC_WIDTH-1:0]          acc_m;
  logic [DEC_WIDTH-1:0]          acc_c;
  logic [1:0]                    ret_n;

  function automatic int lane_stn(int l);
    lane_stn = (l < LN_VEC0) ? l : ((l < LN_LOAD) ? STN_VEC : STN_MEM);
  endfunction

  function automatic logic lane_fits(tuwd_uop_t u, int l);
    lane_fits = 1'b1;
    if (l == LN_VEC0) lane_fits = (u.op != OP_FADD);
    if (l == LN_VEC1) lane_fits = u.op inside {OP_VALU, OP_VSHUF, OP_FADD};
    if (l == LN_LOAD) lane_fits = (u.mem == MEM_LOAD);
    if (l == LN_STORE) lane_fits = (u.mem == MEM_STORE);
  endfunction

  function automatic int pick_stn(tuwd_op_t op, int slot);
    case (op)
      OP_SHIFT, OP_F2I:                        pick_stn = 0;
      OP_BIT, OP_BRANCH, OP_MUL, OP_DIV,
      OP_POPCNT, OP_CRC:                       pick_stn = 1;
      OP_FLAGM:                                pick_stn = 2;
      OP_STD:                                  pick_stn = slot % 2;
      OP_VALU, OP_VSHUF, OP_FMUL, OP_FADD:     pick_stn = STN_VEC;
      default:                                 pick_stn = slot;
    endcase
  endfunction

  assign fetch_ready = (IQ_N - int'(iq_cnt_reg)) >= DEC_WIDTH;
  assign push_n      = fetch_ready ? fetch_count : 2'h0;

  // Lowest ready slot per lane; second lane of a station skips the first
  always_comb begin
    int   ls;
    logic lo;
    int   li;
    ls = -1;
    lo = 1'b0;
    li = 0;
    for (int l = 0; l < N_LANE; l++) begin
      pick_ok[l]  = 1'b0;
      pick_idx[l] = '0;
      for (int e = RS_N - 1; e >= 0; e--) begin
        if (st_v_reg[lane_stn(l)][e] &&
            (!st_u_reg[lane_stn(l)][e].wait_mem ||
             rob_dm_reg[st_u_reg[lane_stn(l)][e].rob]) &&
            lane_fits(st_u_reg[lane_stn(l)][e], l) &&
            !(lo && ls == lane_stn(l) && li == e)) begin
          pick_ok[l]  = 1'b1;
          pick_idx[l] = RS_W'(e);
        end
      end
      ls = lane_stn(l);
      lo = pick_ok[l];
      li = int'(pick_idx[l]);
    end
  end

  // Decode and allocate from the queue head, strictly in order
  always_comb begin
    logic [N_STN-1:0][RS_N-1:0] tv;
    tuwd_uop_t                  tu [N_STN][RS_N];
    tuwd_insn_t                 ins;
    tuwd_uop_t                  u;
    logic [6:0]                 byt;
    logic [2:0]                 uops;
    logic                       stop;
    logic                       ok;
    logic                       need;
    logic                       hit;
    int                         s;
    tv   = '0;
    tu   = st_u_reg;
    ins  = '0;
    u    = '0;
    byt  = '0;
    uops = '0;
    stop = 1'b0;
    ok   = 1'b0;
    need = 1'b0;
    hit  = 1'b0;
    s    = 0;
    st_v_next = st_v_reg;
    st_u_next = st_u_reg;
    take_n    = '0;
    acc_m     = '0;
    acc_c     = '0;
    for (int l = 0; l < N_LANE; l++)
      if (pick_ok[l]) st_v_next[lane_stn(l)][pick_idx[l]] = 1'b0;
    for (int i = 0; i < DEC_WIDTH; i++) begin
      ins = iq_reg[IQ_W'(iq_head_reg + IQ_W'(i))];
      tv  = st_v_next;
      tu  = st_u_next;
      ok  = !stop && (i < int'(iq_cnt_reg)) &&
            (int'(byt) + int'(ins.len) <= DEC_BYTES);
      if (int'(uops) + int'(ins.mem != MEM_NONE) + int'(ins.has_op)
          > ALLOC_UOPS) ok = 1'b0;
      if (int'(rob_cnt_reg) + int'(take_n) >= ROB_N) ok = 1'b0;
      for (int k = 0; k < 2; k++) begin
        need       = (k == 0) ? (ins.mem != MEM_NONE) : ins.has_op;
        s          = (k == 0) ? STN_MEM : pick_stn(ins.op, i);
        u.op       = ins.op;
        u.mem      = (k == 0) ? ins.mem : MEM_NONE;
        u.is_mem   = (k == 0);
        u.wait_mem = (k == 1) && (ins.mem == MEM_LOAD);
        u.rob      = ROB_W'(rob_head_reg + ROB_W'(rob_cnt_reg)
                     + ROB_W'(take_n));
        u.id       = ins.id;
        hit        = 1'b0;
        for (int e = 0; e < RS_N; e++) begin
          if (need && !hit && !tv[s][e]) begin
            hit      = 1'b1;
            tv[s][e] = 1'b1;
            tu[s][e] = u;
          end
        end
        if (need && !hit) ok = 1'b0;
      end
      if (ok) begin
        st_v_next = tv;
        st_u_next = tu;
        acc_m[i]  = (ins.mem != MEM_NONE);
        acc_c[i]  = ins.has_op;
        byt       = byt + 7'(ins.len);
        uops      = uops + 3'(acc_m[i]) + 3'(acc_c[i]);
        take_n    = take_n + 2'h1;
      end else begin
        stop = 1'b1;
      end
    end
  end

  // Queue pointers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      iq_head_reg <= '0;
      iq_cnt_reg  <= '0;
    end else begin
      iq_head_reg <= iq_head_reg + IQ_W'(take_n);
      iq_cnt_reg  <= iq_cnt_reg + (IQ_W+1)'(push_n) - (IQ_W+1)'(take_n);
    end
  end

  // Queue storage
  always_ff @(posedge mclk) begin
    for (int j = 0; j < DEC_WIDTH; j++)
      if (j < int'(push_n))
        iq_reg[IQ_W'(iq_head_reg + IQ_W'(iq_cnt_reg) + IQ_W'(j))] <=
          fetch_insn[j];
  end

  // Station occupancy and issue registers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_v_reg    <= '0;
      issue_valid <= '0;
    end else begin
      st_v_reg    <= st_v_next;
      issue_valid <= pick_ok;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      issue_uop <= '0;
    end else begin
      for (int l = 0; l < N_LANE; l++)
        issue_uop[l] <= st_u_reg[lane_stn(l)][pick_idx[l]];
    end
  end

  always_ff @(posedge mclk) begin
    st_u_reg <= st_u_next;
  end

  always_comb begin
    logic run;
    run   = 1'b1;
    ret_n = '0;
    for (int r = 0; r < RET_WIDTH; r++) begin
      if (run && rob_v_reg[ROB_W'(rob_head_reg + ROB_W'(r))] &&
          rob_dm_reg[ROB_W'(rob_head_reg + ROB_W'(r))] &&
          rob_dc_reg[ROB_W'(rob_head_reg + ROB_W'(r))])
        ret_n = ret_n + 2'h1;
      else
        run = 1'b0;
    end
  end

  // Reorder buffer state: allocate, finish, retire
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rob_v_reg    <= '0;
      rob_dm_reg   <= '0;
      rob_dc_reg   <= '0;
      rob_head_reg <= '0;
      rob_cnt_reg  <= '0;
    end else begin
      for (int r = 0; r < RET_WIDTH; r++)
        if (r < int'(ret_n))
          rob_v_reg[ROB_W'(rob_head_reg + ROB_W'(r))] <= 1'b0;
      for (int l = 0; l < N_LANE; l++) begin
        if (cmp_valid[l] && cmp_info[l].is_mem)
          rob_dm_reg[cmp_info[l].rob] <= 1'b1;
        if (cmp_valid[l] && !cmp_info[l].is_mem)
          rob_dc_reg[cmp_info[l].rob] <= 1'b1;
      end
      for (int i = 0; i < DEC_WIDTH; i++) begin
        if (i < int'(take_n)) begin
          rob_v_reg[ROB_W'(rob_head_reg + ROB_W'(rob_cnt_reg)
                    + ROB_W'(i))] <= 1'b1;
          rob_dm_reg[ROB_W'(rob_head_reg + ROB_W'(rob_cnt_reg)
                     + ROB_W'(i))] <= !acc_m[i];
          rob_dc_reg[ROB_W'(rob_head_reg + ROB_W'(rob_cnt_reg)
                     + ROB_W'(i))] <= !acc_c[i];
        end
      end
      rob_head_reg <= rob_head_reg + ROB_W'(ret_n);
      rob_cnt_reg  <= rob_cnt_reg + (ROB_W+1)'(take_n)
                      - (ROB_W+1)'(ret_n);
    end
  end

  always_ff @(posedge mclk) begin
    for (int i = 0; i < DEC_WIDTH; i++)
      if (i < int'(take_n))
        rob_id_reg[ROB_W'(rob_head_reg + ROB_W'(rob_cnt_reg) + ROB_W'(i))]
          <= iq_reg[IQ_W'(iq_head_reg + IQ_W'(i))].id;
  end

  // Retire outputs
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ret_valid <= '0;
      ret_id    <= '0;
    end else begin
      for (int r = 0; r < RET_WIDTH; r++) begin
        ret_valid[r] <= (r < int'(ret_n));
        ret_id[r]    <= rob_id_reg[ROB_W'(rob_head_reg + ROB_W'(r))];
      end
    end
  end
endmodule

// ===== dv/tuwd_core_assertions.sv
// Port-level checker for the three-wide uop dispatch core
`timescale 1ns/1ns
module tuwd_core_assertions
  import tuwd_pkg::*;
(
  input wire logic                           mclk,
  input wire logic                           resetn,
  input wire logic [1:0]                     fetch_count,
  input wire tuwd_insn_t [DEC_WIDTH-1:0]     fetch_insn,
  input wire logic                           fetch_ready,
  input wire logic [N_LANE-1:0]              issue_valid,
  input wire tuwd_uop_t [N_LANE-1:0]         issue_uop,
  input wire logic [N_LANE-1:0]              cmp_valid,
  input wire tuwd_cmp_t [N_LANE-1:0]         cmp_info,
  input wire logic [RET_WIDTH-1:0]           ret_valid,
  input wire logic [RET_WIDTH-1:0][ID_W-1:0] ret_id
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  ret_prefix_a: assert property (
    ret_valid inside {3'h0, 3'h1, 3'h3, 3'h7})
    else $error("retire valid is not an oldest-first prefix");
  int0_units_a: assert property (
    issue_valid[0] |-> !issue_uop[0].is_mem &&
    issue_uop[0].op inside {OP_ALU, OP_SHIFT, OP_LEA, OP_F2I, OP_STD})
    else $error("integer port 0 got a foreign op");
  int1_units_a: assert property (
    issue_valid[1] |-> !issue_uop[1].is_mem && issue_uop[1].op inside
    {OP_ALU, OP_LEA, OP_STD, OP_BIT, OP_BRANCH, OP_MUL, OP_DIV, OP_POPCNT,
     OP_CRC})
    else $error("integer port 1 got a foreign op");
  int2_units_a: assert property (
    issue_valid[2] |-> !issue_uop[2].is_mem &&
    issue_uop[2].op inside {OP_ALU, OP_LEA, OP_FLAGM})
    else $error("integer port 2 got a foreign op");
  vec0_units_a: assert property (
    issue_valid[LN_VEC0] |->
    issue_uop[LN_VEC0].op inside {OP_VALU, OP_VSHUF, OP_FMUL})
    else $error("vector port 0 got a foreign op");
  vec1_units_a: assert property (
    issue_valid[LN_VEC1] |->
    issue_uop[LN_VEC1].op inside {OP_VALU, OP_VSHUF, OP_FADD})
    else $error("vector port 1 got a foreign op");
  load_lane_a: assert property (
    issue_valid[LN_LOAD] |->
    issue_uop[LN_LOAD].is_mem && issue_uop[LN_LOAD].mem == MEM_LOAD)
    else $error("load address lane got a non-load uop");
  store_lane_a: assert property (
    issue_valid[LN_STORE] |->
    issue_uop[LN_STORE].is_mem && issue_uop[LN_STORE].mem == MEM_STORE)
    else $error("store address lane got a non-store uop");
  reset_idle_a: assert property (
    $rose(resetn) |-> fetch_ready && issue_valid == '0 && ret_valid == '0)
    else $error("core not idle on the first edge after reset");

  cover property (issue_valid[LN_LOAD] && issue_valid[LN_STORE]);
  cover property (issue_valid[2:0] == 3'h7);
  cover property (ret_valid == 3'h7);
  cover property (!fetch_ready && fetch_count != 2'h0);
endmodule

bind tuwd_core tuwd_core_assertions tuwd_core_assertions_i (
  .mclk(mclk), .resetn(resetn), .fetch_count(fetch_count),
  .fetch_insn(fetch_insn), .fetch_ready(fetch_ready),
  .issue_valid(issue_valid), .issue_uop(issue_uop), .cmp_valid(cmp_valid),
  .cmp_info(cmp_info), .ret_valid(ret_valid), .ret_id(ret_id));

// ===== dv/tuwd_exec_model.sv
// Execution and memory units that finish issued uops after a delay
`timescale 1ns/1ns
module tuwd_exec_model
  import tuwd_pkg::*;
(
  input  wire logic                   mclk,
  input  wire logic                   resetn,
  input  wire logic                   slow,
  input  wire logic [N_LANE-1:0]      issue_valid,
  input  wire tuwd_uop_t [N_LANE-1:0] issue_uop,
  output      logic [N_LANE-1:0]      cmp_valid,
  output      tuwd_cmp_t [N_LANE-1:0] cmp_info
);
  typedef struct packed {
    logic [31:0] due;
    tuwd_cmp_t   c;
  } tuwd_job_t;
  tuwd_job_t   pend[N_LANE][$];
  tuwd_job_t   j;
  logic [31:0] cyc;
  initial begin
    cmp_valid = '0;
    cmp_info  = '0;
    cyc       = '0;
  end
  always @(negedge mclk) begin
    cyc = cyc + 32'h1;
    for (int l = 0; l < N_LANE; l++) begin
      if (resetn !== 1'b1) begin
        pend[l].delete();
      end else if (issue_valid[l] === 1'b1) begin
        j.due = cyc + (slow ? 32'(1 + $urandom % 6) : 32'h1);
        j.c   = '{issue_uop[l].rob, issue_uop[l].is_mem};
        pend[l].push_back(j);
      end
      cmp_valid[l] = 1'b0;
      // Idle info lines take random values so stale values never pass
      cmp_info[l]  = tuwd_cmp_t'((ROB_W+1)'($urandom));
      if (pend[l].size() != 0 && pend[l][0].due <= cyc) begin
        j            = pend[l].pop_front();
        cmp_valid[l] = 1'b1;
        cmp_info[l]  = j.c;
      end
    end
  end
endmodule

// ===== dv/testbench.sv
// Self-checking bench for the three-wide uop dispatch core
`timescale 1ns/1ns
module testbench
  import tuwd_pkg::*;
;
  logic                           mclk;
  logic                           resetn;
  logic                           slow;
  logic [1:0]                     fetch_count;
  tuwd_insn_t [DEC_WIDTH-1:0]     fetch_insn;
  logic                           fetch_ready;
  logic [N_LANE-1:0]              issue_valid;
  tuwd_uop_t [N_LANE-1:0]         issue_uop;
  logic [N_LANE-1:0]              cmp_valid;
  tuwd_cmp_t [N_LANE-1:0]         cmp_info;
  logic [RET_WIDTH-1:0]           ret_valid;
  logic [RET_WIDTH-1:0][ID_W-1:0] ret_id;
  logic [ID_W-1:0]                exp_q[$];
  logic [ID_W-1:0]                next_id;
  int                             bad_count;
  int                             total_checks;

  tuwd_core tuwd_core_i (.mclk(mclk), .resetn(resetn),
    .fetch_count(fetch_count), .fetch_insn(fetch_insn),
    .fetch_ready(fetch_ready), .issue_valid(issue_valid),
    .issue_uop(issue_uop), .cmp_valid(cmp_valid), .cmp_info(cmp_info),
    .ret_valid(ret_valid), .ret_id(ret_id));
  tuwd_exec_model tuwd_exec_model_i (.mclk(mclk), .resetn(resetn),
    .slow(slow), .issue_valid(issue_valid), .issue_uop(issue_uop),
    .cmp_valid(cmp_valid), .cmp_info(cmp_info));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic cmp_ret(input logic [ID_W-1:0] e, input logic [ID_W-1:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] ret_id expected %h seen %h", e, g);
    end
  endtask

  task automatic cmp_issue(input logic [N_LANE-1:0] e,
                           input logic [N_LANE-1:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] issue_valid expected %h seen %h", e, g);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  function automatic tuwd_insn_t mk(input tuwd_mem_t m, input int h,
                                    input tuwd_op_t o, input int l);
    mk = '{m, 1'(h), o, LEN_W'(l), next_id};
    next_id++;
  endfunction

  // Entered just after a falling edge; junk drives a refused group
  task automatic push(input logic [1:0] n, input tuwd_insn_t [2:0] g,
                      input logic junk);
    int k;
    k = 0;
    while (fetch_ready !== 1'b1 && k < 300) begin
      fetch_count = junk ? 2'h3 : 2'h0;
      fetch_insn  = g;
      k++;
      @(negedge mclk);
    end
    if (k == 300) begin
      bad_count++;
      $display("[ERR] fetch_ready expected 1 seen 0");
    end
    fetch_count = n;
    fetch_insn  = g;
    for (int i = 0; i < n; i++) exp_q.push_back(g[i].id);
    @(negedge mclk);
  endtask

  task automatic drain;
    int k;
    k = 0;
    fetch_count = 2'h0;
    while (exp_q.size() != 0 && k < 3000) begin
      k++;
      @(negedge mclk);
    end
    if (k == 3000) begin
      bad_count++;
      $display("[ERR] retire queue expected empty seen %0d", exp_q.size());
    end
  endtask

  // Push a group and look at the issue lanes two edges later
  task automatic grp(input tuwd_insn_t [2:0] g, input logic [1:0] n,
                     input logic [N_LANE-1:0] e);
    push(n, g, 1'b0);
    fetch_count = 2'h0;
    repeat (2) @(negedge mclk);
    cmp_issue(e, issue_valid);
    drain;
  endtask

  always @(negedge mclk) begin
    if (resetn === 1'b1) begin
      for (int i = 0; i < RET_WIDTH; i++) begin
        if (ret_valid[i] === 1'b1 && exp_q.size() == 0) begin
          bad_count++;
          $display("[ERR] ret_id expected none seen %h", ret_id[i]);
        end else if (ret_valid[i] === 1'b1) begin
          cmp_ret(exp_q.pop_front(), ret_id[i]);
        end
      end
    end
  end

  initial begin
    repeat (60000) @(posedge mclk);
    bad_count++;
    $display("[ERR] run expected done seen watchdog");
    give_verdict();
  end

  initial begin
    tuwd_insn_t [2:0] g;
    void'($urandom(32'h961A));
    resetn = 1'b0;
    slow = 1'b0;
    fetch_count = 2'h0;
    fetch_insn = '0;
    next_id = '0;
    bad_count = 0;
    total_checks = 0;
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    resetn = 1'b1;
    @(negedge mclk);
    g = '{mk(MEM_NONE, 1, OP_ALU, 1), mk(MEM_NONE, 1, OP_ALU, 1),
          mk(MEM_LOAD, 1, OP_ALU, 3)};
    grp(g, 2'h1, 7'h20);
    $display("test split walk done");
    g = '{mk(MEM_NONE, 1, OP_ALU, 6), mk(MEM_NONE, 1, OP_ALU, 7),
          mk(MEM_NONE, 1, OP_ALU, 7)};
    grp(g, 2'h3, 7'h07);
    g = '{mk(MEM_NONE, 1, OP_ALU, 7), mk(MEM_NONE, 1, OP_ALU, 7),
          mk(MEM_NONE, 1, OP_ALU, 7)};
    grp(g, 2'h3, 7'h03);
    $display("test byte budget done");
    // Store-with-op and bare load use all three uop slots; ALU waits
    g = '{mk(MEM_NONE, 1, OP_ALU, 2), mk(MEM_LOAD, 0, OP_ALU, 2),
          mk(MEM_STORE, 1, OP_ALU, 2)};
    grp(g, 2'h3, 7'h61);
    $display("test uop budget done");
    g = '{mk(MEM_NONE, 1, OP_ALU, 2), mk(MEM_STORE, 0, OP_ALU, 4),
          mk(MEM_LOAD, 0, OP_ALU, 4)};
    grp(g, 2'h2, 7'h60);
    $display("test load store pair done");
    for (int r = 0; r < 400; r++) begin
      slow = r[6];
      for (int s = 0; s < DEC_WIDTH; s++)
        g[s] = mk(tuwd_mem_t'(2'($urandom % 3)), $urandom % 2,
                  tuwd_op_t'(4'($urandom)), 1 + $urandom % 10);
      push(2'($urandom % 4), g, 1'b1);
    end
    drain;
    $display("test random stream done");
    give_verdict();
  end
endmodule
